/* src/prs_phy_control_port_if.sv */
// request and answer between the sequencer and its phy port engine
`timescale 1ns/1ps
interface prs_pcp_if;
	logic        req;
	logic        we;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rdata;

	modport seq  (output req, we, addr, wdata, input done, rdata);
	modport port (input req, we, addr, wdata, output done, rdata);
endinterface

/* src/prs_phy_control_port_port.sv */
// phy control port engine: one access at a time, strobe held until ack
`timescale 1ns/1ps
module prs_pcp_port
	import prs_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        clk_en_i,
	// sequencer side
	prs_pcp_if.port          pcp,
	// phy control port pins
	output logic      [15:0] phy_addr_o,
	output logic      [15:0] phy_wdata_o,
	output logic             phy_wr_o,
	output logic             phy_rd_o,
	input  wire logic [15:0] phy_rdata_i,
	input  wire logic        phy_ack_i
);

	typedef struct packed {
		prs_port_state_type st;
		logic               wr;
		logic               rd;
		logic [15:0]        addr;
		logic [15:0]        wdata;
		logic [15:0]        rdata;
		logic               done;
	} prs_port_reg_type;

	prs_port_reg_type r_reg;
	prs_port_reg_type r_next;

	// ==========================================================
	// next state
	always_comb begin
		r_next      = r_reg;
		r_next.done = 1'b0;
		case (r_reg.st)
			PRS_PORT_IDLE: begin
				if (pcp.req) begin
					r_next.st    = PRS_PORT_BUSY;
					r_next.wr    = pcp.we;
					r_next.rd    = !pcp.we;
					r_next.addr  = pcp.addr;
					r_next.wdata = pcp.wdata;
				end
			end
			PRS_PORT_BUSY: begin
				// no timeout: a silent phy stalls the sequencer by design
				if (phy_ack_i) begin
					r_next.st    = PRS_PORT_IDLE;
					r_next.wr    = 1'b0;
					r_next.rd    = 1'b0;
					r_next.rdata = phy_rdata_i;
					r_next.done  = 1'b1;
				end
			end
			default: r_next = '0;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_reg <= '0;
		end else if (clk_en_i) begin
			r_reg <= r_next;
		end
	end

	assign pcp.done    = r_reg.done;
	assign pcp.rdata   = r_reg.rdata;
	assign phy_addr_o  = r_reg.addr;
	assign phy_wdata_o = r_reg.wdata;
	assign phy_wr_o    = r_reg.wr;
	assign phy_rd_o    = r_reg.rd;

endmodule // prs_pcp_port

/* src/prs_pkg.sv */
// constants and types shared by the rate-change recovery sequencer
package prs_pkg;

	// ==========================================================
	// software register offsets and fields
	localparam logic [4:0]  PRS_SW_CTRL        = 5'h00;
	localparam logic [4:0]  PRS_SW_STATUS      = 5'h04;
	localparam logic [4:0]  PRS_SW_IRQ_STAT    = 5'h08;
	localparam logic [4:0]  PRS_SW_IRQ_MASK    = 5'h0C;
	localparam logic [4:0]  PRS_SW_EQ          = 5'h10;
	localparam int unsigned PRS_CTRL_COLD      = 0;
	localparam int unsigned PRS_CTRL_PARTNER   = 1;
	localparam int unsigned PRS_CTRL_L2_ENTER  = 2;
	localparam int unsigned PRS_CTRL_L2_EXIT   = 3;
	localparam int unsigned PRS_IRQ_W          = 4;
	localparam int unsigned PRS_IRQ_GEN2_STUCK = 0;
	localparam int unsigned PRS_IRQ_GEN1_STUCK = 1;
	localparam int unsigned PRS_IRQ_LINK_UP    = 2;
	localparam int unsigned PRS_IRQ_L2_ENTERED = 3;
	localparam logic [3:0]  PRS_IRQ_MASK_RST   = 4'h0;
	localparam logic [2:0]  PRS_EQ_DEFAULT     = 3'h0;

	// ==========================================================
	// phy control port addresses and values
	localparam logic [15:0] PRS_PHY_RX_CTRL    = 16'h1005;
	localparam logic [15:0] PRS_PHY_RX_OVRD_HI = 16'h1006;
	localparam logic [15:0] PRS_PHY_RX_STAT    = 16'h100D;
	localparam logic [15:0] PRS_PHY_RX_DIS     = 16'h0028;
	localparam logic [15:0] PRS_PHY_RX_EN      = 16'h0000;
	localparam logic [15:0] PRS_PHY_RXVLD_MASK = 16'h0001;
	localparam int unsigned PRS_EQ_LSB         = 8;
	localparam int unsigned PRS_EQ_OVRD_BIT    = 11;

	// ==========================================================
	// controller configuration space
	localparam logic [11:0] PRS_CFG_LINKCAP    = 12'h07C;
	localparam logic [11:0] PRS_CFG_GEN2_CTRL  = 12'h80C;
	localparam logic [31:0] PRS_CFG_SPEED_MASK = 32'h0000000F;
	localparam logic [31:0] PRS_CFG_SPEED_GEN1 = 32'h00000001;
	localparam logic [31:0] PRS_CFG_SPEED_GEN2 = 32'h00000002;
	localparam logic [31:0] PRS_CFG_DSC_BIT    = 32'h00020000;
	localparam logic [4:0]  PRS_LTSSM_RCVRLOCK = 5'h0D;

	// ==========================================================
	// timing
	localparam int unsigned PRS_CLK_PERIOD_NS    = 8;
	localparam int unsigned PRS_STUCK_WAIT_NS    = 2000000;
	localparam int unsigned PRS_TRAIN_TIMEOUT_NS = 24000000;
	localparam int unsigned PRS_WAIT_CYCLES      =
		(PRS_STUCK_WAIT_NS + PRS_CLK_PERIOD_NS - 1) / PRS_CLK_PERIOD_NS;

	// ==========================================================
	// state encodings
	typedef enum logic [4:0] {
		PRS_IDLE     = 5'b00000,
		PRS_CS_OFF   = 5'b00001,
		PRS_CS_ON    = 5'b00010,
		PRS_WAIT_L0  = 5'b00011,
		PRS_GEN2_CAP = 5'b00100,
		PRS_GEN2_REQ = 5'b00101,
		PRS_LOAD     = 5'b00110,
		PRS_WAIT     = 5'b00111,
		PRS_CHK      = 5'b01000,
		PRS_EVAL     = 5'b01001,
		PRS_RST_DIS  = 5'b01010,
		PRS_RST_EN   = 5'b01011,
		PRS_LINK_UP  = 5'b01100,
		PRS_EQ_WR    = 5'b01101,
		PRS_L2       = 5'b01110,
		PRS_L2_WAKE  = 5'b01111,
		PRS_CFG_RD   = 5'b10000,
		PRS_CFG_LAT  = 5'b10001,
		PRS_PHY_WAIT = 5'b10010
	} prs_state_type;

	typedef enum logic [0:0] {
		PRS_PORT_IDLE = 1'b0,
		PRS_PORT_BUSY = 1'b1
	} prs_port_state_type;

endpackage

/* src/prs_seq.sv */
// gen1/gen2 rate-change recovery sequencer with software registers
//
// How it works
// [RULE1] cold start: ltssm off, gen2 capability off, ltssm on, wait for L0.
// [RULE2] gen2 is requested from L0 only when both link ends support it.
// [RULE3] after the gen2 request wait 2 ms, inside the 24 ms timeout.
// [RULE4] rcvrlock with receiver-valid low after the wait means stuck.
// [RULE5] L2 entry from L0 waits 2 ms and runs the same stuck check.
// [RULE6] L2 exit: gen2 off, ltssm released, L0, then full cold start.
// [RULE7] receiver reset writes 0028 then 0000 to phy address 1005.
// [RULE8] receiver-valid is bit 0 of a phy read of address 100D.
// [RULE9] gen2 capability is cleared by read-modify-write of link cap.
// [RULE10] gen2 is requested by setting the directed speed-change bit.
// [RULE11] L0 is taken from data link active, never earlier.
// [RULE12] the phy equaliser stays at 3'b000 unless overridden.
// [RULE13] override register 1006 holds value in 10:8, enable in 11.
// [RULE14] after a receiver reset the wait and check are repeated.
// [RULE15] each stuck transition sets an interrupt status flag.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module prs_seq
	import prs_pkg::*;
#(
	parameter int unsigned WAIT_CYCLES = PRS_WAIT_CYCLES
) (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        clk_en_i,
	// software port
	input  wire logic [4:0]  sw_addr_i,
	input  wire logic [31:0] sw_wdata_i,
	input  wire logic        sw_wr_i,
	input  wire logic        sw_rd_i,
	output logic      [31:0] sw_rdata_o,
	output logic             irq_o,
	// controller core
	output logic             ltssm_enable_o,
	output logic             l2_request_o,
	input  wire logic [4:0]  ltssm_state_i,
	input  wire logic        dl_active_i,
	// configuration space port
	output logic      [11:0] cfg_addr_o,
	output logic      [31:0] cfg_wdata_o,
	output logic             cfg_wr_o,
	output logic             cfg_rd_o,
	input  wire logic [31:0] cfg_rdata_i,
	// phy control port
	output logic      [15:0] phy_addr_o,
	output logic      [15:0] phy_wdata_o,
	output logic             phy_wr_o,
	output logic             phy_rd_o,
	input  wire logic [15:0] phy_rdata_i,
	input  wire logic        phy_ack_i
);

	localparam int unsigned TW = $clog2(WAIT_CYCLES + 1);

	typedef struct packed {
		prs_state_type  st;
		prs_state_type  ret;
		logic [TW-1:0]  timer;
		logic           ltssm_en;
		logic           l2_req;
		logic           gen2_cap;
		logic           partner;
		logic           chk_gen1;
		logic           redo;
		logic           cold_pend;
		logic           l2in_pend;
		logic           l2out_pend;
		logic           eq_pend;
		logic [2:0]     eq_val;
		logic           eq_ovr;
		logic [3:0]     irq_stat;
		logic [3:0]     irq_mask;
		logic [31:0]    sw_rdata;
		logic [11:0]    cfg_addr;
		logic [31:0]    cfg_wdata;
		logic [31:0]    cfg_mask;
		logic [31:0]    cfg_set;
		logic           cfg_wr;
		logic           cfg_rd;
		logic           phy_req;
		logic           phy_we;
		logic [15:0]    phy_addr;
		logic [15:0]    phy_wdata;
		logic           rx_valid;
	} prs_seq_reg_type;

	prs_seq_reg_type r_reg;
	prs_seq_reg_type r_next;
	logic [3:0]      ev;
	logic            stuck;

	prs_pcp_if pcp ();

	// ==========================================================
	// next state
	always_comb begin
		r_next         = r_reg;
		r_next.cfg_rd  = 1'b0;
		r_next.cfg_wr  = 1'b0;
		r_next.phy_req = 1'b0;
		r_next.sw_rdata = '0;
		ev             = '0;
		stuck          = (ltssm_state_i == PRS_LTSSM_RCVRLOCK) &&
			!r_reg.rx_valid; // [RULE4]
		case (r_reg.st)
			PRS_IDLE: begin
				if (r_reg.cold_pend) begin
					r_next.cold_pend = 1'b0;
					r_next.st        = PRS_CS_OFF;
				end else if (r_reg.eq_pend) begin
					r_next.ret = PRS_IDLE;
					r_next.st  = PRS_EQ_WR;
				end
			end
			PRS_CS_OFF: begin
				// ltssm drops before the capability write is issued
				r_next.ltssm_en = 1'b0; // [RULE1]
				r_next.gen2_cap = 1'b0;
				r_next.cfg_rd   = 1'b1; // [RULE9]
				r_next.cfg_addr = PRS_CFG_LINKCAP;
				r_next.cfg_mask = PRS_CFG_SPEED_MASK;
				r_next.cfg_set  = PRS_CFG_SPEED_GEN1;
				r_next.ret      = PRS_CS_ON;
				r_next.st       = PRS_CFG_RD;
			end
			PRS_CS_ON: begin
				r_next.ltssm_en = 1'b1; // [RULE1]
				r_next.st       = PRS_WAIT_L0;
			end
			PRS_WAIT_L0: begin
				if (dl_active_i) begin // [RULE11]
					if (r_reg.redo) begin
						r_next.redo = 1'b0; // [RULE6]
						r_next.st   = PRS_CS_OFF;
					end else if (r_reg.partner) begin
						r_next.st = PRS_GEN2_CAP; // [RULE2]
					end else begin
						ev[PRS_IRQ_LINK_UP] = 1'b1;
						r_next.st           = PRS_LINK_UP;
					end
				end
			end
			PRS_GEN2_CAP: begin
				r_next.gen2_cap = 1'b1;
				r_next.cfg_rd   = 1'b1;
				r_next.cfg_addr = PRS_CFG_LINKCAP;
				r_next.cfg_mask = PRS_CFG_SPEED_MASK;
				r_next.cfg_set  = PRS_CFG_SPEED_GEN2;
				r_next.ret      = PRS_GEN2_REQ;
				r_next.st       = PRS_CFG_RD;
			end
			PRS_GEN2_REQ: begin
				r_next.chk_gen1 = 1'b0;
				r_next.cfg_rd   = 1'b1; // [RULE10]
				r_next.cfg_addr = PRS_CFG_GEN2_CTRL;
				r_next.cfg_mask = PRS_CFG_DSC_BIT;
				r_next.cfg_set  = PRS_CFG_DSC_BIT;
				r_next.ret      = PRS_LOAD;
				r_next.st       = PRS_CFG_RD;
			end
			PRS_LOAD: begin
				r_next.timer = TW'(WAIT_CYCLES - 1); // [RULE3]
				r_next.st    = PRS_WAIT;
			end
			PRS_WAIT: begin
				if (r_reg.timer == '0) begin
					r_next.st = PRS_CHK;
				end else begin
					r_next.timer = r_reg.timer - 1'b1; // [RULE3]
				end
			end
			PRS_CHK: begin
				r_next.phy_req  = 1'b1; // [RULE8]
				r_next.phy_we   = 1'b0;
				r_next.phy_addr = PRS_PHY_RX_STAT;
				r_next.ret      = PRS_EVAL;
				r_next.st       = PRS_PHY_WAIT;
			end
			PRS_EVAL: begin
				if (stuck) begin
					ev[PRS_IRQ_GEN1_STUCK] = r_reg.chk_gen1; // [RULE15]
					ev[PRS_IRQ_GEN2_STUCK] = !r_reg.chk_gen1;
					r_next.st              = PRS_RST_DIS;
				end else if (r_reg.chk_gen1) begin
					ev[PRS_IRQ_L2_ENTERED] = 1'b1;
					r_next.st              = PRS_L2;
				end else begin
					ev[PRS_IRQ_LINK_UP] = 1'b1;
					r_next.st           = PRS_LINK_UP;
				end
			end
			PRS_RST_DIS: begin
				r_next.phy_req   = 1'b1; // [RULE7]
				r_next.phy_we    = 1'b1;
				r_next.phy_addr  = PRS_PHY_RX_CTRL;
				r_next.phy_wdata = PRS_PHY_RX_DIS;
				r_next.ret       = PRS_RST_EN;
				r_next.st        = PRS_PHY_WAIT;
			end
			PRS_RST_EN: begin
				r_next.phy_req   = 1'b1; // [RULE7]
				r_next.phy_we    = 1'b1;
				r_next.phy_addr  = PRS_PHY_RX_CTRL;
				r_next.phy_wdata = PRS_PHY_RX_EN;
				r_next.ret       = PRS_LOAD; // [RULE14]
				r_next.st        = PRS_PHY_WAIT;
			end
			PRS_LINK_UP: begin
				if (r_reg.cold_pend) begin
					r_next.cold_pend = 1'b0;
					r_next.st        = PRS_CS_OFF;
				end else if (r_reg.eq_pend) begin
					r_next.ret = PRS_LINK_UP;
					r_next.st  = PRS_EQ_WR;
				end else if (r_reg.l2in_pend) begin
					r_next.l2in_pend = 1'b0; // [RULE5]
					r_next.l2_req    = 1'b1;
					r_next.chk_gen1  = 1'b1;
					r_next.st        = PRS_LOAD;
				end
			end
			PRS_EQ_WR: begin
				// with the enable clear the phy keeps its fixed default
				r_next.eq_pend   = 1'b0; // [RULE12]
				r_next.phy_req   = 1'b1;
				r_next.phy_we    = 1'b1;
				r_next.phy_addr  = PRS_PHY_RX_OVRD_HI;
				r_next.phy_wdata = '0;
				r_next.phy_wdata[PRS_EQ_LSB +: 3]   = r_reg.eq_val; // [RULE13]
				r_next.phy_wdata[PRS_EQ_OVRD_BIT]   = r_reg.eq_ovr;
				r_next.st        = PRS_PHY_WAIT;
			end
			PRS_L2: begin
				if (r_reg.l2out_pend) begin
					r_next.l2out_pend = 1'b0; // [RULE6]
					r_next.l2_req     = 1'b0;
					r_next.gen2_cap   = 1'b0;
					r_next.redo       = 1'b1;
					r_next.cfg_rd     = 1'b1;
					r_next.cfg_addr   = PRS_CFG_LINKCAP;
					r_next.cfg_mask   = PRS_CFG_SPEED_MASK;
					r_next.cfg_set    = PRS_CFG_SPEED_GEN1;
					r_next.ret        = PRS_L2_WAKE;
					r_next.st         = PRS_CFG_RD;
				end
			end
			PRS_L2_WAKE: begin
				r_next.ltssm_en = 1'b1; // [RULE6]
				r_next.st       = PRS_WAIT_L0;
			end
			PRS_CFG_RD: r_next.st = PRS_CFG_LAT;
			PRS_CFG_LAT: begin
				r_next.cfg_wr    = 1'b1; // [RULE9]
				r_next.cfg_wdata = (cfg_rdata_i & ~r_reg.cfg_mask) |
					r_reg.cfg_set;
				r_next.st        = r_reg.ret;
			end
			PRS_PHY_WAIT: begin
				if (pcp.done) begin
					if (!r_reg.phy_we) begin
						r_next.rx_valid =
							|(pcp.rdata & PRS_PHY_RXVLD_MASK); // [RULE8]
					end
					r_next.st = r_reg.ret;
				end
			end
			default: r_next.st = PRS_IDLE;
		endcase

		// software reads; status read clears, but a new event still lands
		if (sw_rd_i) begin
			case (sw_addr_i)
				PRS_SW_CTRL: r_next.sw_rdata = {28'h0, r_reg.l2out_pend,
					r_reg.l2in_pend, r_reg.partner, r_reg.cold_pend};
				PRS_SW_STATUS: r_next.sw_rdata = {18'h0, ltssm_state_i,
					r_reg.st, r_reg.gen2_cap, r_reg.l2_req,
					r_reg.ltssm_en, dl_active_i};
				PRS_SW_IRQ_STAT: r_next.sw_rdata = {28'h0, r_reg.irq_stat};
				PRS_SW_IRQ_MASK: r_next.sw_rdata = {28'h0, r_reg.irq_mask};
				PRS_SW_EQ: r_next.sw_rdata = {20'h0, r_reg.eq_ovr,
					r_reg.eq_val, 8'h00};
				default: r_next.sw_rdata = '0;
			endcase
		end
		r_next.irq_stat = ((sw_rd_i && sw_addr_i == PRS_SW_IRQ_STAT) ?
			4'h0 : r_reg.irq_stat) | ev; // [RULE15]

		// software writes come last so a command never gets lost
		if (sw_wr_i) begin
			case (sw_addr_i)
				PRS_SW_CTRL: begin
					r_next.partner = sw_wdata_i[PRS_CTRL_PARTNER];
					if (sw_wdata_i[PRS_CTRL_COLD]) begin
						r_next.cold_pend = 1'b1;
					end
					if (sw_wdata_i[PRS_CTRL_L2_ENTER]) begin
						r_next.l2in_pend = 1'b1;
					end
					if (sw_wdata_i[PRS_CTRL_L2_EXIT]) begin
						r_next.l2out_pend = 1'b1;
					end
				end
				PRS_SW_IRQ_MASK: r_next.irq_mask = sw_wdata_i[3:0];
				PRS_SW_EQ: begin
					r_next.eq_val  = sw_wdata_i[PRS_EQ_LSB +: 3]; // [RULE13]
					r_next.eq_ovr  = sw_wdata_i[PRS_EQ_OVRD_BIT];
					r_next.eq_pend = 1'b1;
				end
				default: r_next.eq_pend = r_next.eq_pend;
			endcase
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_reg          <= '0;
			r_reg.irq_mask <= PRS_IRQ_MASK_RST;
			r_reg.eq_val   <= PRS_EQ_DEFAULT;
		end else if (clk_en_i) begin
			r_reg <= r_next;
		end
	end

	// ==========================================================
	// outputs and phy port engine
	assign sw_rdata_o     = r_reg.sw_rdata;
	assign irq_o          = |(r_reg.irq_stat & r_reg.irq_mask);
	assign ltssm_enable_o = r_reg.ltssm_en;
	assign l2_request_o   = r_reg.l2_req;
	assign cfg_addr_o     = r_reg.cfg_addr;
	assign cfg_wdata_o    = r_reg.cfg_wdata;
	assign cfg_wr_o       = r_reg.cfg_wr;
	assign cfg_rd_o       = r_reg.cfg_rd;
	assign pcp.req       = r_reg.phy_req;
	assign pcp.we        = r_reg.phy_we;
	assign pcp.addr      = r_reg.phy_addr;
	assign pcp.wdata     = r_reg.phy_wdata;

	prs_pcp_port u_port (
		.sys_clk_i   (sys_clk_i),
		.nrst_i      (nrst_i),
		.clk_en_i    (clk_en_i),
		.pcp         (pcp),
		.phy_addr_o  (phy_addr_o),
		.phy_wdata_o (phy_wdata_o),
		.phy_wr_o    (phy_wr_o),
		.phy_rd_o    (phy_rd_o),
		.phy_rdata_i (phy_rdata_i),
		.phy_ack_i   (phy_ack_i)
	);

	// ==========================================================
	// checks
	property p_ltssm_gen1;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(ltssm_enable_o) |-> !r_reg.gen2_cap;
	endproperty
	a_ltssm_gen1: assert property (p_ltssm_gen1) // [RULE1]
		else $error("ltssm released with gen2 capability on");

	property p_dsc_partner;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(cfg_wr_o && cfg_addr_o == PRS_CFG_GEN2_CTRL) |->
			r_reg.partner && (cfg_wdata_o & PRS_CFG_DSC_BIT) != '0;
	endproperty
	a_dsc_partner: assert property (p_dsc_partner) // [RULE2]
		else $error("speed change requested without gen2 partner");

	property p_dsc_l0;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(clk_en_i && r_reg.st == PRS_WAIT_L0 && !dl_active_i) |=>
			r_reg.st == PRS_WAIT_L0;
	endproperty
	a_dsc_l0: assert property (p_dsc_l0) // [RULE11]
		else $error("left L0 wait before data link active");

	property p_wait_holds;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(clk_en_i && r_reg.st == PRS_WAIT && r_reg.timer != '0) |=>
			r_reg.st == PRS_WAIT && r_reg.timer == $past(r_reg.timer) - 1'b1;
	endproperty
	a_wait_holds: assert property (p_wait_holds) // [RULE3]
		else $error("stuck check taken before the wait ran out");

	property p_stuck_reset;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(clk_en_i && r_reg.st == PRS_EVAL && stuck) |=>
			r_reg.st == PRS_RST_DIS &&
			(r_reg.irq_stat[PRS_IRQ_GEN1_STUCK] ||
			r_reg.irq_stat[PRS_IRQ_GEN2_STUCK]);
	endproperty
	a_stuck_reset: assert property (p_stuck_reset) // [RULE4]
		else $error("stuck link not reset or not flagged");

	property p_rx_ctrl_data;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(phy_wr_o && phy_addr_o == PRS_PHY_RX_CTRL) |->
			phy_wdata_o == PRS_PHY_RX_DIS || phy_wdata_o == PRS_PHY_RX_EN;
	endproperty
	a_rx_ctrl_data: assert property (p_rx_ctrl_data) // [RULE7]
		else $error("bad value written to receiver control");

	property p_rx_read;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(clk_en_i && r_reg.st == PRS_CHK) |=>
			pcp.req && !pcp.we && pcp.addr == PRS_PHY_RX_STAT;
	endproperty
	a_rx_read: assert property (p_rx_read) // [RULE8]
		else $error("stuck check did not read receiver status");

	property p_rmw;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(cfg_wr_o && $past(clk_en_i) && $past(clk_en_i, 2)) |->
			$past(cfg_rd_o, 2) && $past(cfg_addr_o, 2) == cfg_addr_o;
	endproperty
	a_rmw: assert property (p_rmw) // [RULE9]
		else $error("config write without preceding read");

	property p_eq_write;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(phy_wr_o && phy_addr_o == PRS_PHY_RX_OVRD_HI) |->
			phy_wdata_o[PRS_EQ_LSB +: 3] == r_reg.eq_val &&
			phy_wdata_o[PRS_EQ_OVRD_BIT] == r_reg.eq_ovr;
	endproperty
	a_eq_write: assert property (p_eq_write) // [RULE13]
		else $error("override write does not match equaliser register");

endmodule // prs_seq

/* test/prs_far_model.sv */
// controller core, config space and phy register file behavioural model
`timescale 1ns/1ps
module prs_far_model
	import prs_pkg::*;
(
	// clock, reset and scenario controls
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [1:0]  stuck_n_i,
	input  wire logic        stuck_ld_i,
	input  wire logic [3:0]  ack_dly_i,
	// core
	input  wire logic        ltssm_enable_i,
	input  wire logic        l2_request_i,
	output logic      [4:0]  ltssm_state_o,
	output logic             dl_active_o,
	// config space and phy control port
	input  wire logic [11:0] cfg_addr_i,
	input  wire logic [31:0] cfg_wdata_i,
	input  wire logic        cfg_wr_i,
	input  wire logic        cfg_rd_i,
	output logic      [31:0] cfg_rdata_o,
	input  wire logic [15:0] phy_addr_i,
	input  wire logic [15:0] phy_wdata_i,
	input  wire logic        phy_wr_i,
	input  wire logic        phy_rd_i,
	output logic      [15:0] phy_rdata_o,
	output logic             phy_ack_o,
	// observation
	output logic      [31:0] linkcap_o,
	output logic      [31:0] gen2ctl_o,
	output logic      [2:0]  eq_o,
	output logic      [3:0]  rst_cnt_o,
	output logic      [31:0] gap_o,
	output logic             bad_o
);
	logic [15:0] rx_ctl, ovrd, rd_q;
	logic [31:0] cfg_q, tick;
	logic [3:0]  cnt;
	logic [1:0]  stuck;
	logic        cfg_v, en_q;
	// ==========================================================
	// outputs; released lines show the inverse of their last value
	assign eq_o = ovrd[11] ? ovrd[10:8] : 3'h0;
	assign ltssm_state_o = (stuck != 2'h0) ? PRS_LTSSM_RCVRLOCK : 5'h11;
	assign cfg_rdata_o = cfg_v ? cfg_q : ~cfg_q;
	assign phy_rdata_o = phy_ack_o ? rd_q : ~rd_q;
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{rx_ctl, ovrd, rd_q, cfg_q, tick, cnt, stuck} <= '0;
			{cfg_v, en_q, dl_active_o, bad_o, phy_ack_o} <= '0;
			{rst_cnt_o, gap_o, gen2ctl_o} <= '0;
			linkcap_o <= PRS_CFG_SPEED_GEN2;
		end else begin
			en_q <= ltssm_enable_i;
			dl_active_o <= ltssm_enable_i & ~l2_request_i;
			// training may only be released at gen1 speed
			if (ltssm_enable_i && !en_q && linkcap_o[3:0] != 4'h1)
				bad_o <= 1'b1;
			if (stuck_ld_i)
				stuck <= stuck_n_i;
			cfg_v <= cfg_rd_i;
			tick <= tick + 32'h1;
			if (cfg_rd_i)
				cfg_q <= (cfg_addr_i == PRS_CFG_LINKCAP) ? linkcap_o : gen2ctl_o;
			if (cfg_wr_i && cfg_addr_i == PRS_CFG_LINKCAP)
				linkcap_o <= cfg_wdata_i;
			if (cfg_wr_i && cfg_addr_i == PRS_CFG_GEN2_CTRL) begin
				gen2ctl_o <= cfg_wdata_i;
				gap_o <= '0;
				tick <= '0;
			end
			phy_ack_o <= 1'b0;
			if ((phy_wr_i || phy_rd_i) && !phy_ack_o) begin
				cnt <= cnt + 4'h1;
				if (cnt >= ack_dly_i) begin
					phy_ack_o <= 1'b1;
					cnt <= 4'h0;
					if (phy_wr_i && phy_addr_i == PRS_PHY_RX_CTRL) begin
						rx_ctl <= phy_wdata_i;
						if (rx_ctl == PRS_PHY_RX_DIS && phy_wdata_i == PRS_PHY_RX_EN) begin
							rst_cnt_o <= rst_cnt_o + 4'h1;
							if (stuck != 2'h0)
								stuck <= stuck - 2'h1;
						end
					end
					if (phy_wr_i && phy_addr_i == PRS_PHY_RX_OVRD_HI)
						ovrd <= phy_wdata_i;
					// upper bits set so that a missing mask shows
					if (phy_rd_i && phy_addr_i == PRS_PHY_RX_STAT) begin
						rd_q <= {15'h2AAA, stuck == 2'h0};
						if (gap_o == 32'h0)
							gap_o <= tick;
					end else if (phy_rd_i)
						rd_q <= (phy_addr_i == PRS_PHY_RX_OVRD_HI) ? ovrd : rx_ctl;
				end
			end
		end
	end
endmodule // prs_far_model

/* test/prs_seq_test.sv */
// self-checking bench for the rate-change recovery sequencer
`timescale 1ns/1ps
module prs_seq_test;
	import prs_pkg::*;
	localparam int unsigned WAIT = 20;
	logic        sys_clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [4:0]  sw_addr_i = '0;
	logic [31:0] sw_wdata_i = '0;
	logic        sw_wr_i = 1'b0;
	logic        sw_rd_i = 1'b0;
	logic [1:0]  stuck_n = '0;
	logic        stuck_ld = 1'b0;
	logic [3:0]  ack_dly = '0;
	logic [31:0] sw_rdata_o, cfg_wdata_o, cfg_rdata_i, linkcap, gen2ctl, gap, d;
	logic [15:0] phy_addr_o, phy_wdata_o, phy_rdata_i;
	logic [11:0] cfg_addr_o;
	logic [4:0]  ltssm_state_i;
	logic [3:0]  rst_cnt;
	logic [2:0]  eq;
	logic        irq_o, ltssm_enable_o, l2_request_o, dl_active_i, bad;
	logic        cfg_wr_o, cfg_rd_o, phy_wr_o, phy_rd_o, phy_ack_i;
	int          fails = 0;
	int          compares = 0;
	int          cycles = 0;
	// ==========================================================
	// design and far side
	prs_seq #(.WAIT_CYCLES(WAIT)) i_prs_seq (.sys_clk_i, .nrst_i,
		.clk_en_i(1'b1), .sw_addr_i, .sw_wdata_i, .sw_wr_i, .sw_rd_i,
		.sw_rdata_o, .irq_o, .ltssm_enable_o, .l2_request_o, .ltssm_state_i,
		.dl_active_i, .cfg_addr_o, .cfg_wdata_o, .cfg_wr_o, .cfg_rd_o,
		.cfg_rdata_i, .phy_addr_o, .phy_wdata_o, .phy_wr_o, .phy_rd_o,
		.phy_rdata_i, .phy_ack_i);
	prs_far_model i_prs_far_model (.sys_clk_i, .nrst_i, .stuck_n_i(stuck_n),
		.stuck_ld_i(stuck_ld), .ack_dly_i(ack_dly),
		.ltssm_enable_i(ltssm_enable_o), .l2_request_i(l2_request_o),
		.ltssm_state_o(ltssm_state_i), .dl_active_o(dl_active_i),
		.cfg_addr_i(cfg_addr_o), .cfg_wdata_i(cfg_wdata_o),
		.cfg_wr_i(cfg_wr_o), .cfg_rd_i(cfg_rd_o), .cfg_rdata_o(cfg_rdata_i),
		.phy_addr_i(phy_addr_o), .phy_wdata_i(phy_wdata_o),
		.phy_wr_i(phy_wr_o), .phy_rd_i(phy_rd_o), .phy_rdata_o(phy_rdata_i),
		.phy_ack_o(phy_ack_i), .linkcap_o(linkcap), .gen2ctl_o(gen2ctl),
		.eq_o(eq), .rst_cnt_o(rst_cnt), .gap_o(gap), .bad_o(bad));
	always #4 sys_clk_i = ~sys_clk_i;
	// a hang counts as a mismatch
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			$display("unexpected at %0t: run timed out", $time);
			print_verdict();
		end
	end
	// ==========================================================
	// bus and compare tasks
	task automatic check(input logic [31:0] got, exp, input string msg);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic sw_write(input logic [4:0] a, input logic [31:0] v);
		@(posedge sys_clk_i);
		sw_addr_i <= a;
		sw_wdata_i <= v;
		sw_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		sw_wr_i <= 1'b0;
	endtask
	task automatic sw_read(input logic [4:0] a, output logic [31:0] v);
		@(posedge sys_clk_i);
		sw_addr_i <= a;
		sw_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		sw_rd_i <= 1'b0;
		#1 v = sw_rdata_o;
	endtask
	// unmask one event, wait for the level, then read-clear the status
	task automatic wait_event(input int b, input logic [31:0] exp);
		sw_write(PRS_SW_IRQ_MASK, 32'h1 << b);
		for (int i = 0; i < 3000 && irq_o !== 1'b1; i++)
			@(posedge sys_clk_i);
		sw_read(PRS_SW_IRQ_STAT, d);
		check(d, exp, "event status");
		check(32'(irq_o), 32'h0, "irq clear");
	endtask
	task automatic load_stuck(input logic [1:0] n, input logic [3:0] dly);
		@(posedge sys_clk_i);
		stuck_n <= n;
		ack_dly <= dly;
		stuck_ld <= 1'b1;
		@(posedge sys_clk_i);
		stuck_ld <= 1'b0;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		check(32'(eq), 32'h0, "eq pin");
		check(32'(irq_o), 32'h0, "irq at reset");
		sw_read(PRS_SW_IRQ_MASK, d);
		check(d, 32'(PRS_IRQ_MASK_RST), "mask reset");
		sw_read(PRS_SW_EQ, d);
		check(d, 32'h0, "eq reset");
		sw_read(5'h14, d);
		check(d, 32'h0, "unmapped read");
	endtask
	task automatic t_cold_gen1();
		sw_write(PRS_SW_CTRL, 32'h1);
		wait_event(2, 32'h4);
		check(linkcap & PRS_CFG_SPEED_MASK, PRS_CFG_SPEED_GEN1, "gen1");
		check(gen2ctl, 32'h0, "no dsc");
		check(32'(bad), 32'h0, "order");
		sw_read(PRS_SW_STATUS, d);
		check(d & 32'hF, 32'h3, "status");
	endtask
	task automatic t_cold_gen2();
		load_stuck(2'h2, 4'h3);
		sw_write(PRS_SW_CTRL, 32'h3);
		wait_event(2, 32'h5);
		check(32'(rst_cnt), 32'h2, "rx resets");
		check(linkcap & PRS_CFG_SPEED_MASK, PRS_CFG_SPEED_GEN2, "gen2");
		check(gen2ctl & PRS_CFG_DSC_BIT, PRS_CFG_DSC_BIT, "dsc bit");
		check(32'(gap >= WAIT), 32'h1, "stuck wait");
	endtask
	task automatic t_eq();
		sw_write(PRS_SW_EQ, 32'h00000D00);
		for (int i = 0; i < 200 && eq !== 3'h5; i++)
			@(posedge sys_clk_i);
		check(32'(eq), 32'h5, "eq ovr");
		sw_read(PRS_SW_EQ, d);
		check(d, 32'h00000D00, "eq rd");
	endtask
	task automatic t_l2();
		load_stuck(2'h1, 4'h0);
		sw_write(PRS_SW_CTRL, 32'h6);
		wait_event(3, 32'hA);
		check(32'(l2_request_o), 32'h1, "l2 request");
		check(32'(rst_cnt), 32'h3, "gen1 reset");
		sw_write(PRS_SW_CTRL, 32'hA);
		wait_event(2, 32'h4);
		check(32'(l2_request_o), 32'h0, "l2 off");
		check(linkcap & PRS_CFG_SPEED_MASK, PRS_CFG_SPEED_GEN2, "regen2");
		check(32'(bad), 32'h0, "wake");
	endtask
	task automatic print_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_cold_gen1();
		t_cold_gen2();
		t_eq();
		t_l2();
		print_verdict();
	end
endmodule // prs_seq_test
